// *** design/pdeo_map.vh ***
// Notes on behaviour
// [R01] Software sets pin2 direction for timer1 output
// [R02] Timer1 compare pin also carries PWM
// [R03] SPI master forces pin2 input; slave follows direction
// [R04] Forced-input pin2 pull-up follows its out bit
// [R05] Clock fuse puts divided clock on pin1
// [R06] Divided clock continues during reset
// [R07] SPI slave forces pin0 input unless PSC output 0 is enabled; active when low
// [R08] SPI master: pin0 direction normal; pull-up follows its out bit
// [R09] Pin4 overrides use SPI term; input disable ADC1
// [R10] Pins7..5 no overrides; input disables per source
// [R11] Pin0 direction overrides from PSC and SPI; output overrides from PSC and USART
// [R12] Pin3 output override timer0 A or SPI
// [R13] Software sets porte pin1 direction for timer0 B
// [R14] Porte pin1 value override timer0 B; pin2 ADC0
// [R15] Crystal clock takes porte pin2 from I/O
// [R16] Non-RC clock takes porte pin1 as input
// [R17] Reset fuse programmed: porte pin0 ordinary I/O
// [R18] Reset fuse clear: porte pin0 feeds reset
// [R19] Reset-pin mode reads direction, out, input zero
// [R20] Porte pin0 has no overrides
// [R21] Override enable selects override value over register
`ifndef PDEO_MAP_VH
`define PDEO_MAP_VH
// Clock source select codes
`define PDEO_CKSEL_W 2
`define PDEO_CKSEL_RC 2'h0
`define PDEO_CKSEL_XTAL 2'h1
`define PDEO_CKSEL_LFXTAL 2'h2
`define PDEO_CKSEL_EXT 2'h3
// Pin index positions
`define PDEO_PD0 0
`define PDEO_PD1 1
`define PDEO_PD2 2
`define PDEO_PD3 3
`define PDEO_PD4 4
`define PDEO_PD5 5
`define PDEO_PD6 6
`define PDEO_PD7 7
`define PDEO_PE0 0
`define PDEO_PE1 1
`define PDEO_PE2 2
`endif

// *** design/pdeo_pin_cell.v ***
`timescale 1ns/1ps
`default_nettype none
// One pin's override merge; registered result
module pdeo_pin_cell (
   // Clock and reset
   input wire clk,
   input wire srst,
   // Port register side
   input wire port_pu,
   input wire port_dir,
   input wire port_val,
   input wire port_die,
   // Override pairs
   input wire puoe,
   input wire puov,
   input wire ddoe,
   input wire ddov,
   input wire pvoe,
   input wire pvov,
   input wire dieoe,
   input wire dieov,
   // Registered pin controls
   output reg pu_ff,
   output reg oe_ff,
   output reg out_ff,
   output reg die_ff
);
   // =====================================
   // Override merge
   always @(posedge clk) begin
      if (srst) begin
         pu_ff <= 1'b0;
         oe_ff <= 1'b0;
         out_ff <= 1'b0;
         die_ff <= 1'b0;
      end else begin
         pu_ff <= puoe ? puov : port_pu; // [R21]
         oe_ff <= ddoe ? ddov : port_dir; // [R21]
         out_ff <= pvoe ? pvov : port_val; // [R21]
         die_ff <= dieoe ? dieov : port_die; // [R21]
      end
   end
endmodule
`default_nettype wire

// *** design/pdeo_clk_out.v ***
`timescale 1ns/1ps
`default_nettype none
// Divided clock follower; deliberately ignores srst so output runs in reset
module pdeo_clk_out (
   // Clock
   input wire clk,
   // Divided clock from prescaler and fuse
   input wire div_clk,
   input wire clock_output_fuse,
   // Outputs
   output reg active_ff,
   output reg divided_clock_out
);
   initial active_ff = 1'b0;
   initial divided_clock_out = 1'b0;
   // =====================================
   // Clock output, not gated by reset
   always @(posedge clk) begin
      active_ff <= clock_output_fuse; // [R05]
      divided_clock_out <= clock_output_fuse & div_clk; // [R06]
   end
endmodule
`default_nettype wire

// *** design/pdeo_top.v ***
`timescale 1ns/1ps
`default_nettype none
`include "pdeo_map.vh"
module pdeo_top (
   // Clock and reset
   input wire clk,
   input wire srst,
   // Port D register bits
   input wire [7:0] portd_out,
   input wire [7:0] portd_dir,
   input wire [7:0] portd_pin_in,
   // Port E register bits
   input wire [2:0] porte_out,
   input wire [2:0] porte_dir,
   input wire [2:0] porte_pin_in,
   // SPI controls
   input wire spi_enable_bit,
   input wire spi_master_select,
   input wire spi_pin_select,
   input wire spi_mosi_out,
   input wire spi_sck_out,
   input wire global_pullup_disable,
   // Timers, PSC, USART
   input wire timer1_compare_a_enable,
   input wire timer1_compare_a_out,
   input wire timer0_compare_a_enable,
   input wire timer0_compare_a_out,
   input wire timer0_compare_b_enable,
   input wire timer0_compare_b_out,
   input wire psc0_out0_enable,
   input wire psc0_output0,
   input wire usart_spi_mode_select,
   input wire usart_tx_out,
   // Input disable sources
   input wire adc0_input_disable,
   input wire adc1_input_disable,
   input wire adc2_input_disable,
   input wire adc3_input_disable,
   input wire comparator0_input_disable,
   input wire ext_interrupt0_enable,
   // Fuses and clocks
   input wire clock_output_fuse,
   input wire div_clk,
   input wire [`PDEO_CKSEL_W-1:0] clock_source_sel,
   input wire reset_pin_disable_fuse,
   // Port D pin controls
   output wire [7:0] portd_pullup,
   output wire [7:0] portd_drive_en,
   output wire [7:0] portd_drive_val,
   output wire [7:0] portd_input_disable,
   // Port E pin controls
   output wire [2:0] porte_pullup,
   output wire [2:0] porte_drive_en,
   output wire [2:0] porte_drive_val,
   output wire [2:0] porte_input_disable,
   // Clock and oscillator pins
   output wire divided_clock_out,
   output reg oscillator_in_pin_ff,
   output reg oscillator_out_pin_ff,
   // SPI slave select and reset routing
   output reg spi_slave_active_ff,
   output reg reset_pin_to_reset_ff,
   output reg pin_reset_req_ff,
   // Port E bit 0 read-back
   output reg porte_pin0_direction,
   output reg porte_pin0_out_value,
   output reg porte_pin0_input
);
   // =====================================
   // Common terms
   wire spi_m = spi_enable_bit & spi_master_select & spi_pin_select;
   wire spi_s = spi_enable_bit & ~spi_master_select & spi_pin_select;
   wire xtal_sel = (clock_source_sel == `PDEO_CKSEL_XTAL) | (clock_source_sel == `PDEO_CKSEL_LFXTAL);
   wire osc_in_sel = (clock_source_sel != `PDEO_CKSEL_RC);
   wire divided_clock_out_val;
   // Pin 1 cell stays out of reset while the clock fuse is set, so the clock keeps reaching the pin
   wire [7:0] d_srst = {{6{srst}}, srst & ~clock_output_fuse, srst}; // [R06]
   wire [7:0] d_puoe, d_puov, d_ddoe, d_ddov, d_pvoe, d_pvov, d_dieoe, d_dieov;
   wire [2:0] e_puoe, e_puov, e_ddoe, e_ddov, e_pvoe, e_pvov, e_dieoe, e_dieov;
   wire [7:0] d_pu_port = portd_out & ~portd_dir & {8{~global_pullup_disable}};
   // Reset-pin mode masks porte pin0 register bits before the cells, keeping outputs registered
   wire [2:0] e_out_m = {porte_out[2:1], porte_out[0] & reset_pin_disable_fuse}; // [R18]
   wire [2:0] e_dir_m = {porte_dir[2:1], porte_dir[0] & reset_pin_disable_fuse}; // [R18]
   wire [2:0] e_pu_port = e_out_m & ~e_dir_m & {3{~global_pullup_disable}};
   // =====================================
   // Port D override equations
   assign d_puoe[7:5] = 3'h0; // [R10]
   assign d_puov[7:5] = 3'h0; // [R10]
   assign d_ddoe[7:5] = 3'h0; // [R10]
   assign d_ddov[7:5] = 3'h0; // [R10]
   assign d_pvoe[7:5] = 3'h0; // [R10]
   assign d_pvov[7:5] = 3'h0; // [R10]
   assign d_dieoe[7] = comparator0_input_disable; // [R10]
   assign d_dieoe[6] = adc3_input_disable | ext_interrupt0_enable; // [R10]
   assign d_dieoe[5] = adc2_input_disable; // [R10]
   // Override value one means the digital input is disabled
   assign d_dieov[7:5] = 3'h7; // [R10]
   // Pin 4: SPI clock
   assign d_puoe[4] = spi_m; // [R09]
   assign d_puov[4] = portd_out[4] & ~global_pullup_disable; // [R09]
   assign d_ddoe[4] = spi_m; // [R09]
   assign d_ddov[4] = portd_dir[4];
   assign d_pvoe[4] = spi_m; // [R09]
   assign d_pvov[4] = spi_sck_out;
   assign d_dieoe[4] = adc1_input_disable; // [R09]
   assign d_dieov[4] = 1'b1; // [R09]
   // Pin 3: timer0 compare A or SPI MOSI
   assign d_puoe[3] = spi_m; // [R12]
   assign d_puov[3] = portd_out[3] & ~global_pullup_disable; // [R12]
   assign d_ddoe[3] = spi_m; // [R12]
   assign d_ddov[3] = portd_dir[3]; // [R12]
   assign d_pvoe[3] = timer0_compare_a_enable | spi_m; // [R12]
   assign d_pvov[3] = timer0_compare_a_enable ? timer0_compare_a_out : spi_mosi_out; // [R12]
   assign d_dieoe[3] = 1'b0;
   assign d_dieov[3] = 1'b0;
   // Pin 2: SPI master-in forced input; timer1 A needs direction set by software
   assign d_puoe[2] = spi_m; // [R04]
   assign d_puov[2] = portd_out[2] & ~global_pullup_disable; // [R04]
   assign d_ddoe[2] = spi_m; // [R03]
   assign d_ddov[2] = 1'b0; // [R03]
   assign d_pvoe[2] = timer1_compare_a_enable & portd_dir[2]; // [R01] [R02]
   assign d_pvov[2] = timer1_compare_a_out; // [R02]
   assign d_dieoe[2] = 1'b0;
   assign d_dieov[2] = 1'b0;
   // Pin 1: divided clock output wins over port bits
   assign d_puoe[1] = clock_output_fuse; // [R05]
   assign d_puov[1] = 1'b0;
   assign d_ddoe[1] = clock_output_fuse; // [R05]
   assign d_ddov[1] = 1'b1; // [R05]
   assign d_pvoe[1] = clock_output_fuse; // [R05]
   assign d_pvov[1] = div_clk; // [R05]
   assign d_dieoe[1] = 1'b0;
   assign d_dieov[1] = 1'b0;
   // Pin 0: PSC output, USART, slave select
   assign d_puoe[0] = spi_m | spi_s; // [R07]
   assign d_puov[0] = portd_out[0] & ~global_pullup_disable; // [R08]
   assign d_ddoe[0] = psc0_out0_enable | spi_m | spi_s; // [R11] [R07]
   assign d_ddov[0] = psc0_out0_enable | (spi_m & portd_dir[0]); // [R11] [R08]
   assign d_pvoe[0] = psc0_out0_enable | usart_spi_mode_select; // [R11]
   assign d_pvov[0] = psc0_out0_enable ? psc0_output0 : usart_tx_out; // [R11]
   assign d_dieoe[0] = 1'b0;
   assign d_dieov[0] = 1'b0;
   // =====================================
   // Port E override equations
   assign e_puoe = {xtal_sel, osc_in_sel, 1'b0}; // [R15] [R16] [R20]
   assign e_puov = 3'h0;
   assign e_ddoe = {xtal_sel, osc_in_sel, 1'b0}; // [R15] [R16] [R20]
   assign e_ddov = 3'h0;
   // Timer0 B drives only once software sets the direction bit
   assign e_pvoe = {xtal_sel, ~osc_in_sel & timer0_compare_b_enable & porte_dir[1], 1'b0}; // [R14] [R13] [R20]
   assign e_pvov = {1'b0, timer0_compare_b_out, 1'b0}; // [R14]
   assign e_dieoe = {adc0_input_disable | xtal_sel, osc_in_sel, 1'b0}; // [R14] [R15] [R20]
   assign e_dieov = {1'b1, osc_in_sel, 1'b0}; // [R14]
   // =====================================
   // Pin cells
   genvar i;
   generate
      for (i = 0; i < 8; i = i + 1) begin : g_pd
         pdeo_pin_cell u_cell (
            .clk(clk), .srst(d_srst[i]),
            .port_pu(d_pu_port[i]), .port_dir(portd_dir[i]), .port_val(portd_out[i]), .port_die(1'b0),
            .puoe(d_puoe[i]), .puov(d_puov[i]), .ddoe(d_ddoe[i]), .ddov(d_ddov[i]),
            .pvoe(d_pvoe[i]), .pvov(d_pvov[i]), .dieoe(d_dieoe[i]), .dieov(d_dieov[i]),
            .pu_ff(portd_pullup[i]), .oe_ff(portd_drive_en[i]), .out_ff(portd_drive_val[i]),
            .die_ff(portd_input_disable[i])
         );
      end
      for (i = 0; i < 3; i = i + 1) begin : g_pe
         pdeo_pin_cell u_cell (
            .clk(clk), .srst(srst),
            .port_pu(e_pu_port[i]), .port_dir(e_dir_m[i]), .port_val(e_out_m[i]), .port_die(1'b0),
            .puoe(e_puoe[i]), .puov(e_puov[i]), .ddoe(e_ddoe[i]), .ddov(e_ddov[i]),
            .pvoe(e_pvoe[i]), .pvov(e_pvov[i]), .dieoe(e_dieoe[i]), .dieov(e_dieov[i]),
            .pu_ff(porte_pullup[i]), .oe_ff(porte_drive_en[i]), .out_ff(porte_drive_val[i]),
            .die_ff(porte_input_disable[i])
         );
      end
   endgenerate
   pdeo_clk_out u_clk_out (
      .clk(clk),
      .div_clk(div_clk),
      .clock_output_fuse(clock_output_fuse),
      .active_ff(),
      .divided_clock_out(divided_clock_out_val)
   );
   assign divided_clock_out = divided_clock_out_val; // [R06]
   // =====================================
   // Registered status and routing
   always @(posedge clk) begin
      if (srst) begin
         oscillator_in_pin_ff <= 1'b0;
         oscillator_out_pin_ff <= 1'b0;
         spi_slave_active_ff <= 1'b0;
         reset_pin_to_reset_ff <= 1'b0;
         pin_reset_req_ff <= 1'b0;
         porte_pin0_direction <= 1'b0;
         porte_pin0_out_value <= 1'b0;
         porte_pin0_input <= 1'b0;
      end else begin
         oscillator_in_pin_ff <= osc_in_sel ? porte_pin_in[1] : 1'b0; // [R16]
         oscillator_out_pin_ff <= xtal_sel ? porte_pin_in[2] : 1'b0; // [R15]
         spi_slave_active_ff <= spi_s & ~portd_pin_in[0]; // [R07]
         reset_pin_to_reset_ff <= ~reset_pin_disable_fuse; // [R18] [R17]
         pin_reset_req_ff <= ~reset_pin_disable_fuse & ~porte_pin_in[0]; // [R18]
         porte_pin0_direction <= reset_pin_disable_fuse & porte_dir[0]; // [R19] [R17]
         porte_pin0_out_value <= reset_pin_disable_fuse & porte_out[0]; // [R19]
         porte_pin0_input <= reset_pin_disable_fuse & porte_pin_in[0]; // [R19]
      end
   end
endmodule
`default_nettype wire

// *** verif/pdeo_pin_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// ==========
// Port D package pins and the clock prescaler
module pdeo_pin_model (
   // Clock
   input wire logic clk,
   // Pin controls from the block and from outside parties
   input wire logic [7:0] drive_en,
   input wire logic [7:0] drive_val,
   input wire logic [7:0] pull_en,
   input wire logic [7:0] ext_en,
   input wire logic [7:0] ext_val,
   // Synchronised pin levels and divided clock
   output logic [7:0] pin_level,
   output logic div_clk
);
   logic [1:0] div_cnt;
   initial begin
      div_cnt = 2'h0;
      div_clk = 1'b0;
      pin_level = 8'h00;
   end
   // Prescaler ignores reset, so the clock pin has something to show then
   always @(posedge clk) begin
      div_cnt <= div_cnt + 2'h1;
      div_clk <= div_cnt[1];
   end
   // A floating pin toggles so that no stale level is ever read back
   always @(posedge clk) begin
      pin_level <= (drive_en & drive_val) | (~drive_en & ext_en & ext_val) | (~drive_en & ~ext_en & pull_en)
         | (~drive_en & ~ext_en & ~pull_en & ~pin_level);
   end
endmodule
`default_nettype wire

// *** verif/pdeo_top_checker.sv ***
`timescale 1ns/1ps
`default_nettype none
// ==========
// Override checks on the top ports
module pdeo_top_checker (
   // Clock, reset, fuses
   input wire logic clk, srst, clock_output_fuse, div_clk, reset_pin_disable_fuse,
   input wire logic [1:0] clock_source_sel,
   // Peripheral and port controls
   input wire logic spi_enable_bit, spi_master_select, spi_pin_select, global_pullup_disable,
   input wire logic psc0_out0_enable, psc0_output0, adc2_input_disable, adc3_input_disable,
   input wire logic comparator0_input_disable, ext_interrupt0_enable,
   input wire logic [7:0] portd_out, portd_pin_in,
   // Pin controls
   input wire logic [7:0] portd_pullup, portd_drive_en, portd_drive_val, portd_input_disable,
   input wire logic [2:0] porte_drive_en, porte_input_disable,
   input wire logic spi_slave_active_ff, porte_pin0_direction, porte_pin0_out_value, porte_pin0_input
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);
   wire spi_on = spi_enable_bit & spi_pin_select;
   chk_master_pin2_in: assert property (spi_on & spi_master_select |=> !portd_drive_en[2])
      else $error("master-in pin driven in master mode");
   chk_forced_pullup: assert property (spi_on & spi_master_select & !global_pullup_disable
      |=> portd_pullup[2] == $past(portd_out[2])) else $error("forced input pull-up wrong");
   chk_clock_pin: assert property (clock_output_fuse ##1 clock_output_fuse
      |-> portd_drive_en[1] && portd_drive_val[1] == $past(div_clk)) else $error("clock pin wrong");
   chk_slave_sel_in: assert property (spi_on & !spi_master_select |=> !portd_drive_en[0])
      else $error("slave select pin driven");
   chk_slave_active: assert property (spi_slave_active_ff
      |-> !$past(portd_pin_in[0]) && !$past(spi_master_select) && $past(spi_enable_bit)) else $error("slave active");
   chk_analog_die: assert property (1'b1 |=> portd_input_disable[7:5] == {$past(comparator0_input_disable),
      $past(adc3_input_disable) | $past(ext_interrupt0_enable), $past(adc2_input_disable)}) else $error("die wrong");
   chk_psc_pin0: assert property (psc0_out0_enable & !spi_enable_bit
      |=> portd_drive_en[0] && portd_drive_val[0] == $past(psc0_output0)) else $error("psc pin wrong");
   chk_crystal_pin2: assert property (^clock_source_sel |=> !porte_drive_en[2] && porte_input_disable[2])
      else $error("oscillator pin used as I/O");
   chk_reset_reads: assert property (!reset_pin_disable_fuse ##1 !reset_pin_disable_fuse
      |-> !porte_pin0_direction && !porte_pin0_out_value && !porte_pin0_input) else $error("reset pin reads");
endmodule
`default_nettype wire

// *** verif/tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin err_total++; $display("BAD t=%0t %h %h", $time, g, e); end end
module tb_top;
   // ==========
   // Stimulus and observed pins
   logic clk, srst, spi_enable_bit, spi_master_select, spi_pin_select, global_pullup_disable, dprev;
   logic timer1_compare_a_enable, timer1_compare_a_out, timer0_compare_a_enable, timer0_compare_a_out;
   logic timer0_compare_b_enable, timer0_compare_b_out, psc0_out0_enable, psc0_output0;
   logic adc0_input_disable, adc1_input_disable, adc2_input_disable, adc3_input_disable;
   logic comparator0_input_disable, ext_interrupt0_enable, clock_output_fuse, reset_pin_disable_fuse;
   logic [1:0] clock_source_sel;
   logic [2:0] porte_out, porte_dir, porte_pin_in;
   logic [7:0] portd_out, portd_dir, ext_en, ext_val;
   logic spi_mosi_out, spi_sck_out, usart_spi_mode_select, usart_tx_out;
   wire div_clk, divided_clock_out, spi_slave_active_ff, pin_reset_req_ff;
   wire oscillator_in_pin_ff, oscillator_out_pin_ff, reset_pin_to_reset_ff;
   wire porte_pin0_direction, porte_pin0_out_value, porte_pin0_input;
   wire [7:0] portd_pin_in, portd_pullup, portd_drive_en, portd_drive_val, portd_input_disable;
   wire [2:0] porte_pullup, porte_drive_en, porte_drive_val, porte_input_disable;
   int err_total = 0;
   int comparisons = 0;
   int i;
   pdeo_top dut (.*);
   pdeo_pin_model pins (.clk(clk), .drive_en(portd_drive_en), .drive_val(portd_drive_val), .pull_en(portd_pullup),
      .ext_en(ext_en), .ext_val(ext_val), .pin_level(portd_pin_in), .div_clk(div_clk));
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   task automatic settle();
      repeat (2) @(posedge clk);
      #1;
   endtask
   // Divided clock keeps reaching its pin while reset is held
   task automatic clock_in_reset();
      repeat (4) begin
         dprev = div_clk;
         @(posedge clk);
         #1;
         `CHK({portd_drive_en[1], portd_drive_val[1], divided_clock_out}, {1'b1, dprev, dprev})
      end
   endtask
   task automatic give_verdict();
      if (err_total == 0 && comparisons > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   initial begin
      #20000;
      err_total++;
      give_verdict();
   end
   // ==========
   // Test sequence
   initial begin
      srst = 1'b1;
      {spi_enable_bit, spi_master_select, spi_pin_select, global_pullup_disable} = 4'h0;
      {timer1_compare_a_enable, timer1_compare_a_out, timer0_compare_a_enable, timer0_compare_a_out} = 4'h0;
      {timer0_compare_b_enable, timer0_compare_b_out, psc0_out0_enable, psc0_output0} = 4'h0;
      {adc0_input_disable, adc1_input_disable, adc2_input_disable, adc3_input_disable} = 4'h0;
      {comparator0_input_disable, ext_interrupt0_enable, clock_output_fuse, reset_pin_disable_fuse} = 4'h2;
      {clock_source_sel, porte_out, porte_dir, porte_pin_in} = 11'h000;
      {portd_out, portd_dir, ext_en, ext_val} = 32'h0;
      {spi_mosi_out, spi_sck_out, usart_spi_mode_select, usart_tx_out} = 4'h0;
      #1;
      clock_in_reset();
      clock_in_reset();
      srst = 1'b0;
      for (i = 0; i < 32; i++) begin
         {comparator0_input_disable, adc3_input_disable, ext_interrupt0_enable, adc2_input_disable} = i[4:1];
         adc1_input_disable = i[0];
         global_pullup_disable = i[1];
         portd_dir[7:5] = i[2:0];
         portd_out[7:5] = i[4:2];
         settle();
         `CHK(portd_input_disable[7:4], {i[4], i[3] | i[2], i[1], i[0]})
         `CHK({portd_drive_en[7:5], portd_drive_val[7:5]}, {portd_dir[7:5], portd_out[7:5]})
         `CHK(portd_pullup[7:5], portd_out[7:5] & ~portd_dir[7:5] & {3{~i[1]}})
      end
      {spi_enable_bit, spi_master_select, spi_pin_select, global_pullup_disable} = 4'he;
      for (i = 0; i < 4; i++) begin
         portd_dir[2:0] = {2'h3, i[1]};
         portd_out[2:0] = {i[0], 2'h1};
         {spi_mosi_out, spi_sck_out} = {~i[0], i[0]};
         settle();
         `CHK({portd_drive_en[2], portd_pullup[2]}, {1'b0, i[0]})
         `CHK({portd_drive_en[0], portd_pullup[0]}, {i[1], 1'b1})
         `CHK(portd_drive_val[4:3], {i[0], ~i[0]})
      end
      // Slave: select pin is an input and an outside master pulls it low
      spi_master_select = 1'b0;
      portd_dir[2:0] = 3'h5;
      ext_en[0] = 1'b1;
      for (i = 0; i < 2; i++) begin
         ext_val[0] = i[0];
         // The pin level passes the pin model's register before the block sees it
         repeat (2) settle();
         `CHK({portd_drive_en[2], portd_drive_en[0]}, 2'h2)
         `CHK(spi_slave_active_ff, ~i[0])
      end
      {spi_enable_bit, ext_en[0]} = 2'h0;
      {timer1_compare_a_enable, timer0_compare_a_enable, psc0_out0_enable} = 3'h7;
      usart_spi_mode_select = 1'b1;
      portd_dir[3:0] = 4'hc;
      for (i = 0; i < 2; i++) begin
         {timer1_compare_a_out, timer0_compare_a_out, psc0_output0, usart_tx_out} = {{3{i[0]}}, ~i[0]};
         portd_out[3:0] = {4{~i[0]}};
         settle();
         `CHK({portd_drive_en[3:2], portd_drive_en[0]}, 3'h7)
         `CHK({portd_drive_val[3:2], portd_drive_val[0]}, {3{i[0]}})
      end
      {timer1_compare_a_enable, timer0_compare_a_enable, psc0_out0_enable} = 3'h0;
      {porte_dir, porte_out, timer0_compare_b_enable} = 7'h7f;
      porte_pin_in[2:1] = 2'h3;
      for (i = 0; i < 8; i++) begin
         clock_source_sel = i[1:0];
         {adc0_input_disable, timer0_compare_b_out} = {2{i[2]}};
         usart_tx_out = i[0];
         settle();
         `CHK(porte_drive_en[2:1], {~(i[0] ^ i[1]), i[1:0] == 2'h0})
         `CHK(porte_input_disable[2], (i[0] ^ i[1]) | i[2])
         if (i[1:0] == 2'h0) `CHK(porte_drive_val[1], i[2])
         `CHK({oscillator_in_pin_ff, oscillator_out_pin_ff, portd_drive_val[0]}, {i[1:0] != 2'h0, i[0] ^ i[1], i[0]})
      end
      clock_source_sel = 2'h0;
      for (i = 0; i < 4; i++) begin
         reset_pin_disable_fuse = i[0];
         porte_pin_in[0] = i[1];
         settle();
         `CHK({porte_pin0_direction, porte_pin0_out_value, porte_pin0_input}, {3{i[0]}} & {2'h3, i[1]})
         `CHK({porte_drive_en[0], pin_reset_req_ff, reset_pin_to_reset_ff}, {i[0], ~i[0] & ~i[1], ~i[0]})
      end
      // Clock pin returns to the port once the fuse is cleared
      {clock_output_fuse, portd_dir[1], portd_out[1]} = 3'h3;
      settle();
      `CHK({portd_drive_en[1], portd_drive_val[1]}, 2'h3)
      {clock_output_fuse, portd_dir[1], portd_out[1]} = 3'h4;
      settle();
      srst = 1'b1;
      clock_in_reset();
      srst = 1'b0;
      give_verdict();
   end
endmodule
bind pdeo_top pdeo_top_checker chk (.*);
`default_nettype wire
